// [hw/ddi_bit_shifter.sv]
// Byte shifter clocked by the bus clock, sampling the data line on each rising edge.
`timescale 1ns/1ps
`default_nettype none
module ddi_bit_shifter (
    input wire logic scl_clk_in,
    input wire logic sda_in,
    output logic [7:0] byte_out
);
    logic [7:0] shift_q;
    logic [7:0] shift_d;

    // No reset here: the bus clock stands still outside frames, and the byte is only read
    // after eight fresh edges have filled it.
    always_comb begin
        shift_d = {shift_q[6:0], sda_in};
    end

    always_ff @(posedge scl_clk_in) begin
        shift_q <= shift_d;
    end

    assign byte_out = shift_q;
endmodule
`default_nettype wire

// [hw/ddi_pkg.sv]
// Shared constants and types of the dual DAC two-wire slave interface.
package ddi_pkg;

    localparam logic [4:0] ADDR_HIGH = 5'h03;
    localparam logic [7:0] BCAST_BYTE = 8'h10;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [1:0] IDX_CMD = 2'h0;
    localparam logic [1:0] IDX_MSB = 2'h1;
    localparam logic [1:0] IDX_LSB = 2'h2;
    localparam int BYTE_MODE_BIT = 6;
    localparam int CODE_WIDTH = 16;

    typedef enum logic [1:0] {
        DDI_STRAP_VDD = 2'b00,
        DDI_STRAP_OPEN = 2'b01,
        DDI_STRAP_GND = 2'b10
    } ddi_strap_t;

    localparam logic [1:0] LOW_VDD = 2'b00;
    localparam logic [1:0] LOW_OPEN = 2'b10;
    localparam logic [1:0] LOW_GND = 2'b11;

    typedef enum logic [2:0] {
        DDI_CMD_WRITE_INPUT = 3'b000,
        DDI_CMD_UPDATE_OUTPUT = 3'b001,
        DDI_CMD_WRITE_UPDATE_ALL = 3'b010,
        DDI_CMD_WRITE_UPDATE = 3'b011,
        DDI_CMD_POWER = 3'b100,
        DDI_CMD_RESET = 3'b101,
        DDI_CMD_LOAD_MASK = 3'b110,
        DDI_CMD_REFERENCE = 3'b111
    } ddi_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ = 3'b011,
        ST_SKIP = 3'b100
    } ddi_state_t;

    // The command_and_data_word layout, top bit first.
    typedef struct packed {
        logic reserved;
        logic byte_mode;
        ddi_cmd_t command;
        logic [2:0] channel;
        logic [CODE_WIDTH-1:0] code;
    } ddi_word_t;

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic [2:0] clr_sync;
        logic scl_f;
        logic sda_f;
        logic clr_f;
        ddi_state_t state;
        logic [3:0] bitcnt;
        logic start_fall;
        logic [1:0] byte_idx;
        logic [7:0] cmd;
        logic [7:0] msb;
        logic drive;
        logic nack;
        logic hs;
        logic ref_en;
        logic word_valid;
        logic strap_done;
        logic [1:0] addr_low;
        logic [23:0] tx;
        ddi_word_t word;
    } ddi_main_t;

    localparam ddi_main_t MAIN_RST = '0;

endpackage

// [hw/ddi_slave.sv]
// Two-wire slave front end of the dual DAC: addressing, word assembly and read-back.
// Contract
// (R1) Data code is straight unsigned binary.
// (R2) Reference off after reset, on by command.
// (R3) Seven-bit slave only; no general call.
// (R4) Address 00011 plus strap-selected low bits.
// (R5) Matching address acknowledged on ninth pulse.
// (R6) Nine pulses per unit; data stable high.
// (R7) Master ends a write with a stop.
// (R8) Write is command, high, low; all acknowledged.
// (R9) Read returns three bytes after address acknowledge.
// (R10) Master ends a read with not-acknowledge, stop.
// (R11) Master code goes unacknowledged, enters high speed.
// (R12) Stop returns to standard or fast mode.
// (R13) Clear input also leaves high speed mode.
// (R14) Twenty-four bit word, command byte first.
// (R15) Master keeps the reserved top bit zero.
// (R16) Command byte: byte mode, command, channel.
// (R17) Code left-justified; low bits ignored when narrower.
// (R18) Byte mode reuses command for following pairs.
// (R19) Master clears byte mode for three-byte blocks.
// (R20) Three-bit command field decodes eight commands.
// (R21) Without byte mode every block has command.
// (R22) Broadcast address accepted for writes only.
// (R23) Word delivered only after complete write.
// (R24) Partial word dropped on stop or restart.
// (R25) Unaddressed slave releases data line until start.
`timescale 1ns/1ps
`default_nettype none
module ddi_slave #(
    parameter int RES = 16
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic scl_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire ddi_pkg::ddi_strap_t addr_strap_in,
    input wire logic clear_input_n_in,
    output ddi_pkg::ddi_word_t word_out,
    output logic word_valid_out,
    output logic [RES-1:0] dac_code_out,
    output logic ref_enable_out,
    output logic high_speed_out
);
    ddi_pkg::ddi_main_t q;
    ddi_pkg::ddi_main_t d;
    logic [7:0] rx_byte;
    logic scl_new;
    logic sda_new;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic addr_hit;
    logic byte_end;
    logic ack_end;
    ddi_pkg::ddi_word_t new_word;

    ddi_bit_shifter u_shift (
        .scl_clk_in(scl_clk_in),
        .sda_in(sda_in),
        .byte_out(rx_byte)
    );

    // Line levels change only once the second and third sampling stages agree.
    always_comb begin
        scl_new = (q.scl_sync[1] == q.scl_sync[2]) ? q.scl_sync[2] : q.scl_f;
        sda_new = (q.sda_sync[1] == q.sda_sync[2]) ? q.sda_sync[2] : q.sda_f;
        scl_rise = scl_new & ~q.scl_f;
        scl_fall = ~scl_new & q.scl_f;
        start_ev = q.scl_f & scl_new & q.sda_f & ~sda_new;
        stop_ev = q.scl_f & scl_new & ~q.sda_f & sda_new;
        addr_hit = (rx_byte[7:1] == {ddi_pkg::ADDR_HIGH, q.addr_low}) || // R3 R4
            (rx_byte == ddi_pkg::BCAST_BYTE); // R22
        new_word = {q.cmd, q.msb, rx_byte}; // R14 R16
        byte_end = scl_fall & ~start_ev & ~stop_ev & ~q.start_fall &
            (q.bitcnt == ddi_pkg::LAST_BIT);
        ack_end = scl_fall & ~start_ev & ~stop_ev & ~q.start_fall &
            (q.bitcnt == ddi_pkg::ACK_SLOT);
    end

    always_comb begin
        d = q;
        d.word_valid = 1'b0;
        d.scl_sync = {q.scl_sync[1:0], scl_in};
        d.sda_sync = {q.sda_sync[1:0], sda_in};
        d.clr_sync = {q.clr_sync[1:0], clear_input_n_in};
        d.scl_f = scl_new;
        d.sda_f = sda_new;
        if (q.clr_sync[1] == q.clr_sync[2]) begin
            d.clr_f = q.clr_sync[2];
        end
        // The strap is caught once, on the first edge after reset is released.
        if (!q.strap_done) begin
            d.strap_done = 1'b1;
            if (addr_strap_in == ddi_pkg::DDI_STRAP_OPEN) begin
                d.addr_low = ddi_pkg::LOW_OPEN; // R4
            end else if (addr_strap_in == ddi_pkg::DDI_STRAP_GND) begin
                d.addr_low = ddi_pkg::LOW_GND; // R4
            end else begin
                d.addr_low = ddi_pkg::LOW_VDD; // R4
            end
        end
        if (start_ev) begin
            d.state = ddi_pkg::ST_ADDR;
            d.bitcnt = '0;
            d.byte_idx = ddi_pkg::IDX_CMD; // R24
            d.drive = 1'b0;
            d.nack = 1'b0;
            d.start_fall = 1'b1;
        end else if (stop_ev) begin
            d.state = ddi_pkg::ST_IDLE; // R24 R25
            d.drive = 1'b0;
            d.start_fall = 1'b0;
            d.hs = 1'b0; // R12
        end else if (scl_rise) begin
            if (q.state == ddi_pkg::ST_READ && q.bitcnt == ddi_pkg::ACK_SLOT) begin
                d.nack = sda_new; // R10
            end
        end else if (scl_fall && q.start_fall) begin
            // The fall that closes a start condition carries no bit, so it must not count.
            d.start_fall = 1'b0; // R6
        end else if (scl_fall) begin
            if (q.bitcnt == ddi_pkg::LAST_BIT) begin
                d.bitcnt = ddi_pkg::ACK_SLOT; // R6
                case (q.state)
                    ddi_pkg::ST_ADDR: begin
                        if (addr_hit) begin
                            d.drive = 1'b1; // R5
                            d.tx = q.word;
                            d.state = rx_byte[0] ? ddi_pkg::ST_READ : ddi_pkg::ST_WRITE; // R8 R9
                        end else begin
                            if (rx_byte[7:3] == ddi_pkg::HS_CODE_TOP) begin
                                d.hs = 1'b1; // R11
                            end
                            d.state = ddi_pkg::ST_SKIP; // R25
                        end
                    end
                    ddi_pkg::ST_WRITE: begin
                        d.drive = 1'b1; // R8
                        if (q.byte_idx == ddi_pkg::IDX_CMD) begin
                            d.cmd = rx_byte;
                            d.byte_idx = ddi_pkg::IDX_MSB;
                        end else if (q.byte_idx == ddi_pkg::IDX_MSB) begin
                            d.msb = rx_byte;
                            d.byte_idx = ddi_pkg::IDX_LSB;
                        end else begin
                            d.word = new_word; // R23
                            d.word_valid = 1'b1;
                            // A set byte mode bit keeps the command for the next pair.
                            d.byte_idx = q.cmd[ddi_pkg::BYTE_MODE_BIT] ?
                                ddi_pkg::IDX_MSB : ddi_pkg::IDX_CMD; // R18 R21
                            if (new_word.command == ddi_pkg::DDI_CMD_REFERENCE) begin
                                d.ref_en = rx_byte[0]; // R2 R20
                            end else if (new_word.command == ddi_pkg::DDI_CMD_RESET) begin
                                d.ref_en = 1'b0; // R20
                            end
                        end
                    end
                    ddi_pkg::ST_READ: begin
                        d.drive = 1'b0;
                    end
                    default: begin
                        d.drive = 1'b0;
                    end
                endcase
            end else if (q.bitcnt == ddi_pkg::ACK_SLOT) begin
                d.bitcnt = '0;
                d.drive = 1'b0;
                if (q.state == ddi_pkg::ST_READ) begin
                    if (q.nack) begin
                        d.state = ddi_pkg::ST_SKIP; // R10 R25
                    end else begin
                        d.drive = ~q.tx[23]; // R9
                        d.tx = {q.tx[22:0], q.tx[23]};
                    end
                end
            end else begin
                d.bitcnt = q.bitcnt + 4'h1;
                if (q.state == ddi_pkg::ST_READ) begin
                    d.drive = ~q.tx[23]; // R6 R9
                    d.tx = {q.tx[22:0], q.tx[23]};
                end
            end
        end
        if (q.hs && !q.clr_f) begin
            d.hs = 1'b0; // R13
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            q <= ddi_pkg::MAIN_RST; // R2
        end else begin
            q <= d;
        end
    end

    // Open drain: the pin is only ever pulled low, never driven high.
    assign sda_out = 1'b0;
    assign sda_oe_n_out = ~q.drive;
    assign word_out = q.word;
    assign word_valid_out = q.word_valid;
    assign dac_code_out = q.word.code[ddi_pkg::CODE_WIDTH-1 -: RES]; // R1 R17
    assign ref_enable_out = q.ref_en;
    assign high_speed_out = q.hs;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    AST_REF_OFF_AT_RESET: assert property (@(posedge ref_clk_in) disable iff (1'b0) // R2
        !resetn_in |=> !ref_enable_out)
        else $error("reference enabled right after reset");

    AST_VALID_AFTER_WRITE: assert property ( // R23
        word_valid_out |-> $past(q.state) == ddi_pkg::ST_WRITE && $past(q.bitcnt) == 4'h7)
        else $error("word delivered outside a completed write byte");

    AST_ADDR_ACK: assert property ( // R5
        q.state == ddi_pkg::ST_ADDR && scl_fall && !start_ev && !stop_ev &&
        q.bitcnt == 4'h7 && addr_hit |=> q.drive && !sda_oe_n_out)
        else $error("matching address not acknowledged");

    AST_NO_GENERAL_CALL: assert property ( // R3
        q.state == ddi_pkg::ST_ADDR && scl_fall && !start_ev && !stop_ev &&
        q.bitcnt == 4'h7 && rx_byte == 8'h00 |=> q.state == ddi_pkg::ST_SKIP && !q.drive)
        else $error("general call address answered");

    AST_IDLE_RELEASED: assert property ( // R25
        q.state == ddi_pkg::ST_IDLE || q.state == ddi_pkg::ST_SKIP |-> sda_oe_n_out)
        else $error("data line held while not addressed");

    AST_STOP_LEAVES_HS: assert property ( // R12
        stop_ev && !start_ev |=> !high_speed_out ##1 !high_speed_out || scl_fall)
        else $error("high speed mode kept after stop");

    AST_CLEAR_LEAVES_HS: assert property ( // R13
        high_speed_out && !q.clr_f |=> !high_speed_out)
        else $error("clear input did not leave high speed mode");

    AST_BYTE_MODE_PAIR: assert property ( // R18
        word_valid_out && word_out.byte_mode |-> q.byte_idx == ddi_pkg::IDX_MSB)
        else $error("byte mode did not keep the command byte");

    AST_FULL_BLOCK: assert property ( // R21
        word_valid_out && !word_out.byte_mode |-> q.byte_idx == ddi_pkg::IDX_CMD)
        else $error("three-byte block did not expect a new command");

    AST_UNIT_LENGTH: assert property ( // R6
        q.bitcnt <= 4'h8)
        else $error("bit counter beyond the acknowledge slot");

    AST_START_DROPS_PARTIAL: assert property ( // R24
        start_ev |=> q.byte_idx == ddi_pkg::IDX_CMD && q.state == ddi_pkg::ST_ADDR)
        else $error("partial word kept across a start");

    AST_START_FALL_SKIPPED: assert property ( // R6
        q.start_fall && scl_fall && !start_ev && !stop_ev |=> q.bitcnt == 4'h0)
        else $error("start condition fall counted as a bit");

    AST_BCAST_READ_REFUSED: assert property ( // R22
        byte_end && q.state == ddi_pkg::ST_ADDR && rx_byte == 8'h11 |=> !q.drive)
        else $error("broadcast read acknowledged");

    AST_MASTER_CODE_NO_ACK: assert property ( // R11
        byte_end && q.state == ddi_pkg::ST_ADDR && rx_byte[7:3] == 5'h01 |=> !q.drive)
        else $error("master code acknowledged");

    AST_MASTER_CODE_HS: assert property ( // R11
        byte_end && q.state == ddi_pkg::ST_ADDR && rx_byte[7:3] == 5'h01 |=> high_speed_out)
        else $error("master code did not enter high speed mode");

    AST_MISS_SKIPS: assert property ( // R25
        byte_end && q.state == ddi_pkg::ST_ADDR && !addr_hit |=> q.state == ddi_pkg::ST_SKIP)
        else $error("unmatched address not ignored");

    AST_READ_SELECTED: assert property ( // R9
        byte_end && q.state == ddi_pkg::ST_ADDR && addr_hit && rx_byte[0]
        |=> q.state == ddi_pkg::ST_READ)
        else $error("read address did not start a read");

    AST_WRITE_SELECTED: assert property ( // R8
        byte_end && q.state == ddi_pkg::ST_ADDR && addr_hit && !rx_byte[0]
        |=> q.state == ddi_pkg::ST_WRITE)
        else $error("write address did not start a write");

    AST_DATA_ACK: assert property ( // R8
        byte_end && q.state == ddi_pkg::ST_WRITE |=> q.drive && !sda_oe_n_out)
        else $error("written byte not acknowledged");

    AST_ACK_RELEASED: assert property ( // R6
        ack_end && q.state == ddi_pkg::ST_WRITE |=> sda_oe_n_out)
        else $error("data line held after the acknowledge pulse");

    AST_CMD_CAPTURE: assert property ( // R14
        byte_end && q.state == ddi_pkg::ST_WRITE && q.byte_idx == ddi_pkg::IDX_CMD
        |=> q.cmd == $past(rx_byte))
        else $error("first byte not taken as the command byte");

    AST_REF_BY_CMD: assert property ( // R2
        word_valid_out && word_out.command == ddi_pkg::DDI_CMD_REFERENCE
        |-> ref_enable_out == word_out.code[0])
        else $error("reference setup command not applied");

    AST_RESET_CMD_REF_OFF: assert property ( // R20
        word_valid_out && word_out.command == ddi_pkg::DDI_CMD_RESET |-> !ref_enable_out)
        else $error("reset command left the reference on");

    AST_STOP_IDLE: assert property ( // R24
        stop_ev && !start_ev |=> q.state == ddi_pkg::ST_IDLE)
        else $error("stop did not return the slave to idle");

    AST_NACK_ENDS_READ: assert property ( // R10
        ack_end && q.state == ddi_pkg::ST_READ && q.nack
        |=> q.state == ddi_pkg::ST_SKIP && sda_oe_n_out)
        else $error("read went on after a not-acknowledge");

    AST_WORD_HELD: assert property ( // R23
        !word_valid_out |-> $stable(word_out))
        else $error("word changed without a completed write");

    AST_STRAP_LEGAL: assert property ( // R4
        q.strap_done |-> q.addr_low != 2'b01)
        else $error("strap produced an undefined address");
endmodule
`default_nettype wire

// [verif/ddi_master_model.sv]
// Two-wire bus master model that drives the slave from the far side.
`timescale 1ns/1ps
`default_nettype none
module ddi_master_model (
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    // The low phase is 50 ns so that the slave's synced answer lands before the rise.
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic bit_io(input logic b, output logic s);
        #20 sda_out = b;
        #30 scl_out = 1'b1;
        #10 s = sda_in;
        #20 scl_out = 1'b0;
    endtask
    task automatic start();
        #20 sda_out = 1'b1;
        #30 scl_out = 1'b1;
        #30 sda_out = 1'b0;
        #30 scl_out = 1'b0;
    endtask
    task automatic stop();
        #20 sda_out = 1'b0;
        #30 scl_out = 1'b1;
        #30 sda_out = 1'b1;
        #60;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(nack, s);
    endtask
endmodule
`default_nettype wire

// [verif/ddi_slave_test.sv]
// Self-checking bench for the two-wire slave front end.
`timescale 1ns/1ps
`default_nettype none
module ddi_slave_test;
    logic ref_clk_in = 1'b0;
    logic resetn = 1'b0;
    logic clear_n = 1'b1;
    ddi_pkg::ddi_strap_t strap = ddi_pkg::DDI_STRAP_VDD;
    logic scl, m_sda, sda_bus, sda_oe_n, w_valid, ref_en, hs;
    ddi_pkg::ddi_word_t word;
    logic [15:0] code;
    logic [23:0] last_w = '0;
    logic [7:0] sa;
    int err_total = 0;
    int checked = 0;
    int nwords = 0;
    int cycles = 0;
    // The wire is open drain with a pull-up, so released means high.
    assign sda_bus = m_sda & sda_oe_n;
    always #5 ref_clk_in = ~ref_clk_in;
    ddi_master_model m (.sda_in(sda_bus), .scl_out(scl), .sda_out(m_sda));
    ddi_slave uut (.ref_clk_in(ref_clk_in), .resetn_in(resetn), .scl_clk_in(scl),
        .scl_in(scl), .sda_in(sda_bus), .sda_out(), .sda_oe_n_out(sda_oe_n),
        .addr_strap_in(strap), .clear_input_n_in(clear_n), .word_out(word),
        .word_valid_out(w_valid), .dac_code_out(code), .ref_enable_out(ref_en),
        .high_speed_out(hs));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (w_valid === 1'b1) begin
            nwords <= nwords + 1;
            last_w <= word;
        end
        if (cycles == 60000) begin
            err_total = err_total + 1;
            summarize();
        end
    end
    task automatic do_reset(input int s);
        @(posedge ref_clk_in);
        resetn <= 1'b0;
        strap <= ddi_pkg::ddi_strap_t'(s);
        repeat (2) @(posedge ref_clk_in);
        resetn <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        #3;
    endtask
    task automatic send(input logic [7:0] b, input logic exp);
        logic ack;
        m.wbyte(b, ack);
        check(ack, exp);
    endtask
    task automatic xfer(input logic [23:0] w);
        for (int i = 2; i >= 0; i--) begin
            send(w[i*8 +: 8], 1'b1);
        end
    endtask
    task automatic wr(input logic [23:0] w);
        m.start();
        send(sa, 1'b1);
        xfer(w);
        m.stop();
    endtask
    task automatic wait_hs(input logic v);
        for (int k = 0; k < 20 && hs !== v; k++) begin
            @(posedge ref_clk_in);
            #1;
        end
        check(hs, v);
    endtask
    task automatic t_addr();
        logic [23:0] w;
        for (int i = 0; i < 3; i++) begin
            do_reset(i);
            check(ref_en, 1'b0);
            check(sda_oe_n, 1'b1);
            sa = {ddi_pkg::ADDR_HIGH, i != 0, i == 2, 1'b0};
            w = {8'h01, 16'hffff >> (8 * i)};
            wr(w);
            check(last_w, w);
            check(code, w[15:0]);
        end
        m.start();
        send({ddi_pkg::ADDR_HIGH, 3'b010}, 1'b0);
        m.start();
        send(8'h00, 1'b0);
        m.stop();
    endtask
    task automatic t_multi();
        int n0;
        n0 = nwords;
        m.start();
        send(sa, 1'b1);
        xfer(24'h581234);
        send(8'hab, 1'b1);
        send(8'hcd, 1'b1);
        m.stop();
        check(nwords - n0, 2);
        check(last_w, 24'h58abcd);
        m.start();
        send(sa, 1'b1);
        xfer(24'h001122);
        xfer(24'h093344);
        m.stop();
        check(nwords - n0, 4);
        check(last_w, 24'h093344);
    endtask
    task automatic t_part();
        int n0;
        n0 = nwords;
        m.start();
        send(sa, 1'b1);
        send(8'h02, 1'b1);
        send(8'h55, 1'b1);
        m.stop();
        check(last_w, 24'h093344);
        m.start();
        send(sa, 1'b1);
        send(8'h03, 1'b1);
        wr(24'h037788);
        check(nwords - n0, 1);
        check(last_w, 24'h037788);
    endtask
    task automatic t_bcast();
        logic [7:0] keep;
        keep = sa;
        sa = ddi_pkg::BCAST_BYTE;
        wr(24'h0f0001);
        check(last_w, 24'h0f0001);
        m.start();
        send(ddi_pkg::BCAST_BYTE | 8'h01, 1'b0);
        m.stop();
        sa = keep;
    endtask
    task automatic t_read();
        logic [7:0] b;
        logic [23:0] w;
        w = 24'h1bc3a5;
        wr(w);
        m.start();
        send(sa | 8'h01, 1'b1);
        for (int i = 2; i >= 0; i--) begin
            m.rbyte(i == 0, b);
            check(b, w[i*8 +: 8]);
        end
        m.stop();
        check(sda_oe_n, 1'b1);
    endtask
    task automatic t_cmds();
        for (int c = 0; c < 8; c++) begin
            wr({2'b00, c[2:0], 3'b000, 16'h0001});
            check(last_w[21:19], c[2:0]);
        end
        check(ref_en, 1'b1);
        wr({2'b00, ddi_pkg::DDI_CMD_RESET, 19'h0});
        check(ref_en, 1'b0);
    endtask
    task automatic t_hs();
        m.start();
        send(8'h0b, 1'b0);
        wait_hs(1'b1);
        m.start();
        send(sa, 1'b1);
        xfer(24'h003333);
        wait_hs(1'b1);
        m.stop();
        wait_hs(1'b0);
        m.start();
        send(8'h0f, 1'b0);
        wait_hs(1'b1);
        @(posedge ref_clk_in);
        clear_n <= 1'b0;
        wait_hs(1'b0);
        @(posedge ref_clk_in);
        clear_n <= 1'b1;
        m.stop();
    endtask
    initial begin
        #3;
        t_addr();
        t_multi();
        t_part();
        t_bcast();
        t_read();
        t_cmds();
        t_hs();
        summarize();
    end
endmodule
`default_nettype wire
